// ==== hdl/abi_pkg.sv ====
/*
 * constants, types and the behaviour list for the asynchronous bus interface.
 * assumes one 20 MHz clock, active-low asynchronous reset, pins sampled on rising edges.
 */
// Function
// - size code gives remaining operand length; two low address bits qualify it
// - write lanes come from fixed operand bytes; byte writes replicate lowest byte
// - unaligned three-byte and long writes duplicate upper bytes onto lower lanes
// - marked lane bytes may be driven but are never consumed
// - speculative read aborted on cache hit without ever asserting address strobe
// - cycle start strobes asserted at cycle start when bus is free
// - start strobe may repeat; strobe right after hit abort marks data fetch (prev_abort_ff is recorded but drives no output)
// - acknowledge, fault and halt sampled at states n and n+2
// - acknowledge alone ends cycle normally and continues
// - halt with acknowledge ends cycle then stops bus until halt negated
// - fault without halt ends cycle and raises bus error exception
// - fault with halt ends cycle and reruns once halt is negated
// - arbiter steps on rising edge; grant output changes on falling edge
// - idle owns bus; request moves to grant and three-state both asserted
// - hold grant until acknowledge or request withdrawn, then negate grant
// - keep three-state while acknowledge; on release return idle
// - bus request ignored during read-modify-write
package abi_pkg;
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_3BYTE = 2'h3;
	localparam int SAMPLE_GAP = 2;
	localparam logic [1:0] CNT_RESET = 2'h0;
	typedef enum logic [1:0] {
		ABI_TERM_NORMAL,
		ABI_TERM_HALT,
		ABI_TERM_FAULT,
		ABI_TERM_RETRY
	} abi_term_t;
endpackage : abi_pkg

// ==== hdl/abi_wmux.sv ====
/*
 * write lane multiplexer: picks operand bytes per lane from size code and address.
 * assumes operand byte 3 is least significant; registered output.
 */
`timescale 1ns/1ps
module abi_wmux (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [1:0] size_code,
	input wire logic [1:0] addr_lo,
	input wire logic [31:0] operand,
	output logic [31:0] lanes_ff
);
	import abi_pkg::*;
	logic [7:0] operand_byte_0;
	logic [7:0] operand_byte_1;
	logic [7:0] operand_byte_2;
	logic [7:0] operand_byte_3;
	logic [31:0] nxt_lanes;
	assign operand_byte_0 = operand[31:24];
	assign operand_byte_1 = operand[23:16];
	assign operand_byte_2 = operand[15:8];
	assign operand_byte_3 = operand[7:0];
	always_comb begin
		case ({size_code, addr_lo})
			{SIZE_BYTE, 2'h0}, {SIZE_BYTE, 2'h1}, {SIZE_BYTE, 2'h2}, {SIZE_BYTE, 2'h3}:
				nxt_lanes = {4{operand_byte_3}};
			{SIZE_WORD, 2'h0}, {SIZE_WORD, 2'h2}:
				nxt_lanes = {operand_byte_2, operand_byte_3, operand_byte_2, operand_byte_3};
			{SIZE_WORD, 2'h1}, {SIZE_WORD, 2'h3}:
				nxt_lanes = {operand_byte_2, operand_byte_2, operand_byte_3, operand_byte_2};
			{SIZE_3BYTE, 2'h0}:
				nxt_lanes = {operand_byte_1, operand_byte_2, operand_byte_3, operand_byte_0};
			{SIZE_3BYTE, 2'h1}:
				nxt_lanes = {operand_byte_1, operand_byte_1, operand_byte_2, operand_byte_3};
			{SIZE_3BYTE, 2'h2}:
				nxt_lanes = {operand_byte_1, operand_byte_2, operand_byte_1, operand_byte_2};
			{SIZE_3BYTE, 2'h3}:
				nxt_lanes = {operand_byte_1, operand_byte_1, operand_byte_2, operand_byte_1};
			{SIZE_LONG, 2'h1}:
				nxt_lanes = {operand_byte_0, operand_byte_0, operand_byte_1, operand_byte_2};
			{SIZE_LONG, 2'h2}:
				nxt_lanes = {operand_byte_0, operand_byte_1, operand_byte_0, operand_byte_1};
			{SIZE_LONG, 2'h3}:
				nxt_lanes = {operand_byte_0, operand_byte_0, operand_byte_1, operand_byte_0};
			default:
				nxt_lanes = operand;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lanes_ff <= 32'h0;
		end else begin
			lanes_ff <= nxt_lanes;
		end
	end
endmodule : abi_wmux

// ==== hdl/abi_top.sv ====
/*
 * bus interface top: cycle sequencer, termination resolver and bus arbiter.
 * assumes pins from outside the clock domain; internal core requests on sys_clk.
 */
`timescale 1ns/1ps
module abi_top (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic cyc_req,
	input wire logic cyc_write,
	input wire logic cyc_data,
	input wire logic cyc_rmw,
	input wire logic cache_hit,
	input wire logic [1:0] cyc_size,
	input wire logic [1:0] cyc_addr_lo,
	input wire logic [31:0] cyc_operand,
	input wire logic port_size_ack_n,
	input wire logic bus_fault_in_n,
	input wire logic halt_in_n,
	input wire logic bus_request_in_n,
	input wire logic bus_grant_ack_n,
	output logic size_code_hi,
	output logic size_code_lo,
	output logic [1:0] addr_lo,
	output logic [31:0] data_out,
	output logic data_oe,
	output logic addr_strobe_n,
	output logic external_cycle_start_n,
	output logic operand_cycle_start_n,
	output logic bus_grant_out_n,
	output logic bus_tristate,
	output logic cyc_done,
	output logic cyc_fault,
	output logic cyc_busy
);
	import abi_pkg::*;
	// ====================================================
	// reset and pin synchronisers
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [4:0] pin_s1_ff;
	logic [4:0] pin_s2_ff;
	logic ack_a, fault_a, halt_a, req_a, gack_a;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= 5'h1F;
			pin_s2_ff <= 5'h1F;
		end else begin
			pin_s1_ff <= {port_size_ack_n, bus_fault_in_n, halt_in_n, bus_request_in_n,
				bus_grant_ack_n};
			pin_s2_ff <= pin_s1_ff;
		end
	end
	assign ack_a = ~pin_s2_ff[4];
	assign fault_a = ~pin_s2_ff[3];
	assign halt_a = ~pin_s2_ff[2];
	assign req_a = ~pin_s2_ff[1];
	assign gack_a = ~pin_s2_ff[0];
	// ====================================================
	// bus cycle sequencer
	typedef enum logic [2:0] {
		ABI_IDLE,
		ABI_START,
		ABI_WAIT,
		ABI_SAMPLE2,
		ABI_HALTED
	} abi_cyc_t;
	abi_cyc_t cyc_ff, nxt_cyc;
	logic [1:0] gap_ff, nxt_gap;
	logic first_ack_ff, first_fault_ff, first_halt_ff;
	logic retry_ff, nxt_retry;
	logic prev_abort_ff;
	logic own_bus;
	logic rmw_lock_ff;
	logic [1:0] siz_ff, adr_ff;
	logic w_ff, data_ff;
	abi_term_t term;
	logic sample_end;
	function automatic abi_term_t abi_resolve(input logic ack, input logic flt,
		input logic hlt);
		if (flt && hlt) begin
			return ABI_TERM_RETRY;
		end else if (flt) begin
			return ABI_TERM_FAULT;
		end else if (hlt) begin
			return ABI_TERM_HALT;
		end
		return ABI_TERM_NORMAL;
	endfunction : abi_resolve
	assign sample_end = (cyc_ff == ABI_SAMPLE2) && (gap_ff == CNT_RESET);
	assign term = abi_resolve(first_ack_ff | ack_a, first_fault_ff | fault_a,
		first_halt_ff | halt_a);
	always_comb begin
		nxt_cyc = cyc_ff;
		nxt_gap = gap_ff;
		nxt_retry = retry_ff;
		case (cyc_ff)
			ABI_IDLE: begin
				if ((cyc_req || retry_ff) && own_bus) begin
					nxt_cyc = ABI_START;
				end
			end
			ABI_START: begin
				if (cache_hit && !cyc_data && !cyc_write && !retry_ff) begin
					nxt_cyc = ABI_IDLE;
				end else begin
					nxt_cyc = ABI_WAIT;
				end
			end
			ABI_WAIT: begin
				if (ack_a || fault_a) begin
					nxt_cyc = ABI_SAMPLE2;
					nxt_gap = 2'(SAMPLE_GAP - 1);
				end
			end
			ABI_SAMPLE2: begin
				if (gap_ff != CNT_RESET) begin
					nxt_gap = gap_ff - 2'h1;
				end else begin
					case (term)
						ABI_TERM_NORMAL: begin
							nxt_cyc = ABI_IDLE;
							nxt_retry = 1'b0;
						end
						ABI_TERM_HALT: begin
							nxt_cyc = ABI_HALTED;
							nxt_retry = 1'b0;
						end
						ABI_TERM_FAULT: begin
							nxt_cyc = ABI_IDLE;
							nxt_retry = 1'b0;
						end
						ABI_TERM_RETRY: begin
							nxt_cyc = ABI_HALTED;
							nxt_retry = 1'b1;
						end
						default: nxt_cyc = ABI_IDLE;
					endcase
				end
			end
			ABI_HALTED: begin
				if (!halt_a && !fault_a) begin
					nxt_cyc = ABI_IDLE;
				end
			end
			default: nxt_cyc = ABI_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_ff <= ABI_IDLE;
			gap_ff <= CNT_RESET;
			retry_ff <= 1'b0;
		end else begin
			cyc_ff <= nxt_cyc;
			gap_ff <= nxt_gap;
			retry_ff <= nxt_retry;
		end
	end
	// first sample at state n
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_ack_ff <= 1'b0;
			first_fault_ff <= 1'b0;
			first_halt_ff <= 1'b0;
		end else if (cyc_ff == ABI_WAIT) begin
			first_ack_ff <= ack_a;
			first_fault_ff <= fault_a;
			first_halt_ff <= halt_a;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			siz_ff <= SIZE_LONG;
			adr_ff <= 2'h0;
			w_ff <= 1'b0;
			data_ff <= 1'b0;
			rmw_lock_ff <= 1'b0;
		end else if (cyc_ff == ABI_IDLE && nxt_cyc == ABI_START && !retry_ff) begin
			siz_ff <= cyc_size;
			adr_ff <= cyc_addr_lo;
			w_ff <= cyc_write;
			data_ff <= cyc_data;
			rmw_lock_ff <= cyc_rmw;
		end else if (cyc_ff == ABI_IDLE && !cyc_rmw) begin
			rmw_lock_ff <= 1'b0;
		end
	end
	abi_wmux u_wmux (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.size_code(siz_ff),
		.addr_lo(adr_ff),
		.operand(cyc_operand),
		.lanes_ff(data_out)
	);
	// ====================================================
	// pin outputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			size_code_hi <= 1'b0;
			size_code_lo <= 1'b0;
			addr_lo <= 2'h0;
			data_oe <= 1'b0;
			addr_strobe_n <= 1'b1;
			external_cycle_start_n <= 1'b1;
			operand_cycle_start_n <= 1'b1;
			cyc_done <= 1'b0;
			cyc_fault <= 1'b0;
			cyc_busy <= 1'b0;
			prev_abort_ff <= 1'b0;
		end else begin
			size_code_hi <= siz_ff[1];
			size_code_lo <= siz_ff[0];
			addr_lo <= adr_ff;
			data_oe <= w_ff && (nxt_cyc == ABI_WAIT || nxt_cyc == ABI_SAMPLE2);
			addr_strobe_n <= !(nxt_cyc == ABI_WAIT || nxt_cyc == ABI_SAMPLE2);
			external_cycle_start_n <= !(nxt_cyc == ABI_START);
			operand_cycle_start_n <= !(nxt_cyc == ABI_START && cyc_data);
			cyc_done <= sample_end && term != ABI_TERM_RETRY;
			cyc_fault <= sample_end && term == ABI_TERM_FAULT;
			cyc_busy <= nxt_cyc != ABI_IDLE;
			prev_abort_ff <= cyc_ff == ABI_START && nxt_cyc == ABI_IDLE;
		end
	end
	// ====================================================
	// bus arbiter
	typedef enum logic [2:0] {
		ABI_ARB_OWN,
		ABI_ARB_GRANT,
		ABI_ARB_HOLD,
		ABI_ARB_DROP,
		ABI_ARB_LENT
	} abi_arb_t;
	abi_arb_t arb_ff, nxt_arb;
	logic req_eff;
	logic grant_term;
	logic grant_n_ff;
	assign req_eff = req_a && !rmw_lock_ff && !(cyc_ff != ABI_IDLE && cyc_rmw);
	assign own_bus = (arb_ff == ABI_ARB_OWN) && !req_eff;
	always_comb begin
		nxt_arb = arb_ff;
		case (arb_ff)
			ABI_ARB_OWN: begin
				if (req_eff && cyc_ff == ABI_IDLE) begin
					nxt_arb = ABI_ARB_GRANT;
				end
			end
			ABI_ARB_GRANT: nxt_arb = ABI_ARB_HOLD;
			ABI_ARB_HOLD: begin
				if (gack_a || !req_a) begin
					nxt_arb = ABI_ARB_DROP;
				end
			end
			ABI_ARB_DROP: nxt_arb = ABI_ARB_LENT;
			ABI_ARB_LENT: begin
				if (!gack_a) begin
					nxt_arb = ABI_ARB_OWN;
				end else if (req_a) begin
					nxt_arb = ABI_ARB_GRANT;
				end
			end
			default: nxt_arb = ABI_ARB_OWN;
		endcase
	end
	assign grant_term = (arb_ff == ABI_ARB_GRANT) || (arb_ff == ABI_ARB_HOLD);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arb_ff <= ABI_ARB_OWN;
			bus_tristate <= 1'b0;
		end else begin
			arb_ff <= nxt_arb;
			bus_tristate <= nxt_arb != ABI_ARB_OWN;
		end
	end
	always_ff @(negedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			grant_n_ff <= 1'b1;
		end else begin
			grant_n_ff <= !grant_term;
		end
	end
	assign bus_grant_out_n = grant_n_ff;
	// ====================================================
	// checks
	chk_arb_reset_idle: assert property (@(posedge sys_clk) $rose(rst_n) |->
		arb_ff == ABI_ARB_OWN && !bus_tristate) else $error("arbiter not idle");
	chk_grant_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		arb_ff == ABI_ARB_GRANT |=> arb_ff == ABI_ARB_HOLD) else $error("no hold");
	chk_lent_return: assert property (@(posedge sys_clk) disable iff (!rst_n)
		arb_ff == ABI_ARB_LENT && !gack_a |=> arb_ff == ABI_ARB_OWN && !bus_tristate)
		else $error("no return");
	chk_request_own: assert property (@(posedge sys_clk) disable iff (!rst_n)
		arb_ff == ABI_ARB_OWN && req_eff && cyc_ff == ABI_IDLE |=> ##1 bus_tristate)
		else $error("no grant");
	chk_rmw_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rmw_lock_ff && arb_ff == ABI_ARB_OWN |=> arb_ff == ABI_ARB_OWN)
		else $error("bus lost in rmw");
	chk_abort_no_as: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cyc_ff == ABI_START && nxt_cyc == ABI_IDLE |=> addr_strobe_n)
		else $error("strobe on abort");
	chk_fault_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sample_end && term == ABI_TERM_FAULT |=> cyc_fault && cyc_done)
		else $error("fault lost");
	chk_retry_rerun: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sample_end && term == ABI_TERM_RETRY |=> cyc_ff == ABI_HALTED && retry_ff)
		else $error("no retry");
	chk_halt_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cyc_ff == ABI_HALTED && halt_a |=> cyc_ff == ABI_HALTED)
		else $error("ran under halt");
	chk_grant_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(grant_term) |-> ##1 !bus_grant_out_n) else $error("grant late");
endmodule : abi_top

// ==== testbench/abi_port_model.sv ====
/*
 * far-side port model: answers address strobe with acknowledge, fault or halt.
 * assumes pulled-up pins, so released lines read high; mode and delay come from the bench.
 */
`timescale 1ns/1ps
module abi_port_model (
	input wire logic sys_clk,
	input wire logic addr_strobe_n,
	input wire logic [1:0] mode,
	input wire logic [3:0] delay,
	output logic port_size_ack_n = 1'b1,
	output logic bus_fault_in_n = 1'b1,
	output logic halt_in_n = 1'b1
);
	logic [3:0] cnt = 4'h0;
	logic [3:0] hcnt = 4'h0;
	logic served = 1'b0;
	logic [1:0] m;
	// 0 normal, 1 fault, 2 retry once, 3 halt
	assign m = (mode == 2'h2 && served) ? 2'h0 : mode;
	always @(posedge sys_clk) begin
		if (addr_strobe_n) begin
			cnt <= 4'h0;
			port_size_ack_n <= 1'b1;
			bus_fault_in_n <= 1'b1;
			if (hcnt != 4'h0) hcnt <= hcnt - 4'h1;
			else halt_in_n <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
			if (cnt == delay) begin
				port_size_ack_n <= (m == 2'h1 || m == 2'h2);
				bus_fault_in_n <= !(m == 2'h1 || m == 2'h2);
				halt_in_n <= !(m[1]);
				hcnt <= 4'h6;
				if (m == 2'h2) served <= 1'b1;
			end
		end
		if (mode != 2'h2) served <= 1'b0;
	end
endmodule : abi_port_model

// ==== testbench/abi_top_tb.sv ====
/*
 * self-checking bench for the bus interface top.
 * assumes the port model on the far side and a 20 MHz clock.
 */
`timescale 1ns/1ps
module abi_top_tb;
	import abi_pkg::*;
	logic sys_clk = 0, nrst = 0, req = 0, wr = 0, dat = 0, rmw = 0, hit = 0;
	logic br_n = 1, gack_n = 1;
	logic [1:0] sz = 0, al = 0, mode = 0;
	logic [3:0] dly = 0;
	logic [31:0] op = 0;
	wire ack_n, flt_n, hlt_n, shi, slo, oe, as_n, ecs_n, ocs_n, bg_n, tri_s, done, fault, busy;
	wire [1:0] a_lo;
	wire [31:0] dout;
	int errors = 0, total_checks = 0;
	logic f;
	int nas;
	logic [31:0] ln;
	logic [3:0] sa;
	abi_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .cyc_req(req), .cyc_write(wr),
		.cyc_data(dat), .cyc_rmw(rmw), .cache_hit(hit), .cyc_size(sz), .cyc_addr_lo(al),
		.cyc_operand(op), .port_size_ack_n(ack_n), .bus_fault_in_n(flt_n),
		.halt_in_n(hlt_n), .bus_request_in_n(br_n), .bus_grant_ack_n(gack_n),
		.size_code_hi(shi), .size_code_lo(slo), .addr_lo(a_lo), .data_out(dout),
		.data_oe(oe), .addr_strobe_n(as_n), .external_cycle_start_n(ecs_n),
		.operand_cycle_start_n(ocs_n), .bus_grant_out_n(bg_n), .bus_tristate(tri_s),
		.cyc_done(done), .cyc_fault(fault), .cyc_busy(busy));
	abi_port_model port_u (.sys_clk(sys_clk), .addr_strobe_n(as_n), .mode(mode),
		.delay(dly), .port_size_ack_n(ack_n), .bus_fault_in_n(flt_n), .halt_in_n(hlt_n));
	always #25 sys_clk = ~sys_clk;
	// ==========
	// helpers
	task automatic finish_test();
		if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic wt(input logic gsel, input logic v);
		int k;
		for (k = 0; k < 40 && (gsel ? bg_n : tri_s) !== v; k++) step(1);
		if (k == 40) begin
			errors++;
			finish_test();
		end
	endtask : wt
	// one bus cycle; lock also raises a bus request mid-cycle
	task automatic run(input logic w, input logic [3:0] c, input logic lock);
		int k;
		logic pas;
		wr = w;
		{sz, al} = c;
		rmw = lock;
		req = 1;
		dat = 1;
		nas = 0;
		pas = 1;
		for (k = 0; k < 200 && done !== 1'b1; k++) begin
			step(1);
			if (busy === 1'b1) req = 0;
			if (lock && busy === 1'b1) br_n = 0;
			if (lock) chk(bg_n, 1'b1);
			if (as_n === 1'b0 && pas) begin
				nas++;
				ln = dout;
				sa = {shi, slo, a_lo};
			end
			pas = as_n;
		end
		if (k == 200) begin
			errors++;
			finish_test();
		end
		f = fault;
		step(1);
		br_n = 1;
		step(10);
		rmw = 0;
		step(2);
	endtask : run
	// lane select per byte lane, high lane first; 7 marks an unused byte
	function automatic logic [15:0] sel(input logic [3:0] c);
		casez (c)
			4'b01??: sel = 16'h3333;
			4'b10?0: sel = 16'h2323;
			4'b10?1: sel = 16'h2232;
			4'b1100: sel = 16'h1237;
			4'b1101: sel = 16'h1123;
			4'b1110: sel = 16'h1212;
			4'b1111: sel = 16'h1171;
			4'b0000: sel = 16'h0123;
			4'b0001: sel = 16'h0012;
			4'b0010: sel = 16'h0101;
			default: sel = 16'h0070;
		endcase
	endfunction : sel
	// ==========
	// scenarios
	task automatic t_lanes();
		logic [15:0] s;
		logic [31:0] e, m;
		for (int i = 0; i < 16; i++) begin
			op = 32'hA1B2C3D4 ^ (i << 4);
			s = sel(i[3:0]);
			for (int l = 0; l < 4; l++) begin
				m[31-8*l -: 8] = (s[15-4*l -: 4] == 4'h7) ? 8'h00 : 8'hFF;
				e[31-8*l -: 8] = op[31-8*s[13-4*l -: 2] -: 8];
			end
			run(1, i[3:0], 0);
			chk(ln & m, e & m);
			chk(sa, i);
			chk({f, nas[3:0]}, 5'h01);
		end
	endtask : t_lanes
	task automatic t_terms();
		logic [1:0] md [3] = '{2'h1, 2'h2, 2'h3};
		logic [4:0] ex [3] = '{5'h11, 5'h02, 5'h01};
		for (int i = 0; i < 3; i++) begin
			mode = md[i];
			dly = 4'h3;
			run(0, {SIZE_WORD, 2'h0}, 0);
			chk({f, nas[3:0]}, ex[i]);
		end
		mode = 0;
		dly = 0;
	endtask : t_terms
	task automatic t_hit();
		hit = 1;
		dat = 0;
		wr = 0;
		req = 1;
		for (int k = 0; k < 12; k++) begin
			step(1);
			if (k == 2) req = 0;
			chk(as_n, 1'b1);
		end
		hit = 0;
		step(10);
	endtask : t_hit
	task automatic t_arb();
		// lock keeps bus; only dropping rmw while the sequencer is idle ends it
		run(0, {SIZE_LONG, 2'h0}, 1);
		br_n = 0;
		wt(1, 0);
		chk(tri_s, 1'b1);
		gack_n = 0;
		br_n = 1;
		wt(1, 1);
		chk(tri_s, 1'b1);
		step(4);
		chk({bg_n, tri_s}, 2'h3);
		gack_n = 1;
		wt(0, 0);
		chk({bg_n, as_n}, 2'h3);
	endtask : t_arb
	initial begin
		step(5);
		chk({as_n, ecs_n, ocs_n, bg_n, tri_s, oe}, 6'h3C);
		nrst = 1;
		step(5);
		t_lanes();
		t_terms();
		t_hit();
		t_arb();
		finish_test();
	end
endmodule : abi_top_tb
